/* rtl/pdpa_pkg.sv */
// Purpose: shared constants and types for the post divider and phase align block
// Assumes: one oscillator clock; control bits arrive on the same clock
// Notes: pin function codes follow the two pin function control bits
package pdpa_pkg;
  // default widths of the programmable moduli
  localparam int unsigned POST_W = 8;   // width of each post divider stage modulus
  localparam int unsigned FBK_W = 14;   // width of the feedback divider modulus
  // depth of the pin input synchroniser
  localparam int unsigned SYNC_DEPTH = 3;
  // number of cascaded post divider stages
  localparam int unsigned POST_STAGES = 3;
  // index of each synchronised pin input
  localparam int unsigned SYNC_SLIP = 0;   // slip request
  localparam int unsigned SYNC_LOCK = 1;   // crystal loop lock status
  localparam int unsigned SYNC_RANGE = 2;  // out-of-range direction
  localparam int unsigned SYNC_BITS = 3;
  // reset values of the registered outputs
  localparam logic RST_PIN = 1'h0;
  localparam logic RST_FLAG = 1'h0;
  // pin function modes selected by the two pin function bits
  typedef enum logic [1:0] {
    PDPA_PF_LOCK = 2'h0,    // crystal loop lock status
    PDPA_PF_RANGE = 2'h1,   // out-of-range direction
    PDPA_PF_PHASE = 2'h2,   // phase alignment flag
    PDPA_PF_FBKCLK = 2'h3   // feedback divider clock
  } pdpa_pin_func_t;
endpackage

/* rtl/pdpa_div_if.sv */
// Purpose: carries one divider stage's tick, modulus and outputs
// Assumes: all signals on the oscillator clock
// Notes: the owner drives tick and modulus, the stage answers level and tick
`timescale 1ns/100ps
`default_nettype none
interface pdpa_div_if #(parameter int unsigned W = 8);
  logic tick_in;          // one-cycle enable: one input clock period
  logic [W-1:0] modulus;  // programmed modulus, zero acts as one
  logic level;            // divided clock level
  logic tick_out;         // one-cycle pulse at each divided rising edge
  modport stage (input tick_in, input modulus, output level, output tick_out);
  modport owner (output tick_in, output modulus, input level, input tick_out);
endinterface
`default_nettype wire

/* rtl/pdpa_div_stage.sv */
// Purpose: one programmable divider stage driven by an enable tick
// Assumes: tick_in marks each period of the clock being divided
// Notes: an odd modulus keeps the high part one input period longer
`timescale 1ns/100ps
`default_nettype none
module pdpa_div_stage #(
  parameter int unsigned W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  pdpa_div_if.stage div
);
  logic [W-1:0] cnt;         // position inside the divided period
  logic [W-1:0] next_cnt;
  logic level;
  logic next_level;
  logic tick;
  logic next_tick;
  logic [W-1:0] last;        // terminal count of the period
  logic [W:0] half;          // length of the high part

  // count input ticks, wrap at modulus-1 and shape a balanced level
  always_comb begin
    last = (div.modulus == '0) ? '0 : div.modulus - W'(1);
    half = ({1'b0, div.modulus} + (W+1)'(1)) >> 1;
    next_cnt = cnt;
    next_tick = 1'b0;
    if (div.tick_in) begin
      if (cnt >= last) begin
        next_cnt = '0;  // wrap: one divided clock period done
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
    // ceiling half high, floor half low keeps odd moduli near balanced
    if (last == '0) begin
      next_level = div.tick_in;  // modulus one passes the input tick through
    end else begin
      next_level = ({1'b0, next_cnt} < half);
    end
  end

  // register the stage state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt <= '0;
      level <= 1'b0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
      tick <= next_tick;
    end
  end

  assign div.level = level;
  assign div.tick_out = tick;
endmodule
`default_nettype wire

/* rtl/pdpa_top.sv */
// Purpose: post divider chain, pulse removal, feedback source and phase flag
// Assumes: mclk_in stands for the oscillator; control bits are same-clock levels
// Notes: the slip and crystal loop status inputs are pins and are synchronised
//
// Overview of operation
// - three cascaded programmable post divider stages
// - total modulus is product of three stages
// - each stage of modulus two or more keeps near balanced duty
// - removed oscillator pulse never reaches post divider
// - each slip rising edge delays one period
// - feedback source: oscillator or a count at the post divider rate
// - output clock sampled by feedback divider clock
// - flag inverts when clocks start to match within period
// - pin function two selects phase flag mode
// - phase mode readback returns live flag
// - phase mode push-pull drives flag on pin
// - pin function three outputs feedback divider clock
// - pin driven only with push-pull select set
// - modes zero and one show lock, range
`timescale 1ns/100ps
`default_nettype none
module pdpa_top #(
  parameter int unsigned POST_W = pdpa_pkg::POST_W,
  parameter int unsigned FBK_W = pdpa_pkg::FBK_W
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic slip_request_bit_in,
  input wire logic feedback_source_select_in,
  input wire logic [1:0] pin_function_in,
  input wire logic push_pull_select_in,
  input wire logic [POST_W-1:0] post_modulus1_in,
  input wire logic [POST_W-1:0] post_modulus2_in,
  input wire logic [POST_W-1:0] post_modulus3_in,
  input wire logic [FBK_W-1:0] feedback_modulus_in,
  input wire logic xtal_lock_in,
  input wire logic out_of_range_high_in,
  output logic diff_clock_out_pos_out,
  output logic diff_clock_out_neg_out,
  output logic [3*POST_W-1:0] total_post_modulus_out,
  output logic feedback_clock_out,
  output logic phase_align_flag_out,
  output logic status_readback_out,
  output logic lock_indicator_pin_out,
  output logic lock_indicator_pin_oe_out
);
  localparam int unsigned NS = pdpa_pkg::POST_STAGES;
  localparam int unsigned SB = pdpa_pkg::SYNC_BITS;

  // widen a stage modulus for the product, zero counts as one
  function automatic logic [3*POST_W-1:0] eff_mod(input logic [POST_W-1:0] m);
    eff_mod = (m == '0) ? (3*POST_W)'(1) : (3*POST_W)'(m);
  endfunction

  // ---------------- pin input synchroniser ----------------
  logic [SB-1:0] sync1;         // first stage, read only by sync2
  logic [SB-1:0] sync2;
  logic [SB-1:0] sync3;
  logic [SB-1:0] stable;        // value accepted once sync2 and sync3 agree
  logic [SB-1:0] next_stable;
  logic [SB-1:0] pins_now;

  // gather the asynchronous inputs into one vector
  always_comb begin
    pins_now = '0;
    pins_now[pdpa_pkg::SYNC_SLIP] = slip_request_bit_in;
    pins_now[pdpa_pkg::SYNC_LOCK] = xtal_lock_in;
    pins_now[pdpa_pkg::SYNC_RANGE] = out_of_range_high_in;
  end

  // accept a change only once the last two stages agree, filtering a
  // value still settling out of metastability
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < SB; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_stable[i] = sync3[i];
      end
    end
  end

  // four flip-flops per input, the last holding the accepted value
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      stable <= '0;
    end else begin
      sync1 <= pins_now;
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= next_stable;
    end
  end

  // ---------------- pulse removal ----------------
  logic slip_rise;      // accepted slip went zero to one
  logic gobble;         // suppress the next oscillator pulse
  logic next_gobble;
  logic osc_tick;       // oscillator pulse as seen by the post divider

  // a falling slip request is ignored; a rise removes exactly one pulse
  assign slip_rise = next_stable[pdpa_pkg::SYNC_SLIP] & ~stable[pdpa_pkg::SYNC_SLIP];
  always_comb begin
    next_gobble = slip_rise;
  end

  // register the removal request so it lands on one whole cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      gobble <= 1'b0;
    end else begin
      gobble <= next_gobble;
    end
  end

  // the removed pulse is taken out ahead of the first stage
  assign osc_tick = ~gobble;

  // ---------------- post divider chain ----------------
  pdpa_div_if #(.W(POST_W)) post_if[NS] ();
  logic [POST_W-1:0] post_mod[NS];

  assign post_mod[0] = post_modulus1_in;
  assign post_mod[1] = post_modulus2_in;
  assign post_mod[2] = post_modulus3_in;

  // each stage counts the ticks of the one before it
  for (genvar g = 0; g < NS; g++) begin : g_post
    if (g == 0) begin : g_first
      assign post_if[g].tick_in = osc_tick;
    end else begin : g_next
      assign post_if[g].tick_in = post_if[g-1].tick_out;
    end
    assign post_if[g].modulus = post_mod[g];
    pdpa_div_stage #(.W(POST_W)) u_stage (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .div(post_if[g])
    );
  end

  logic post_level;   // final post divider clock
  logic post_tick;    // rising edge of the final post divider clock
  assign post_level = post_if[NS-1].level;
  assign post_tick = post_if[NS-1].tick_out;

  // ---------------- feedback source reference ----------------
  // in the loop the feedback divider is locked to the input, so a removed
  // pulse moves the output and leaves the feedback clock where it was; a
  // count of all oscillator periods, removed ones too, at the post divider rate stands
  // in for that lock, since this block holds no analog loop
  logic [3*POST_W-1:0] ref_cnt;       // oscillator periods into the post period
  logic [3*POST_W-1:0] next_ref_cnt;
  logic [3*POST_W-1:0] ref_last;      // last count of one post divider period
  logic ref_tick;                     // one pulse per post divider period

  // wrap at the total modulus; a shrinking modulus wraps at once
  always_comb begin
    ref_last = total_post_modulus_out - (3*POST_W)'(1);
    if (total_post_modulus_out == '0) begin
      ref_last = '0;  // only right after reset, before the product lands
    end
    next_ref_cnt = ref_cnt + (3*POST_W)'(1);
    if (ref_cnt >= ref_last) begin
      next_ref_cnt = '0;
    end
  end
  assign ref_tick = (ref_cnt == '0);

  // register the reference count
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ref_cnt <= '0;
    end else begin
      ref_cnt <= next_ref_cnt;
    end
  end

  // ---------------- feedback divider ----------------
  pdpa_div_if #(.W(FBK_W)) fbk_if ();
  logic src_tick;     // feedback source clock period marker

  // the feedback divider runs off the oscillator or the post divider rate;
  // software picks the post divider path before any slip
  assign src_tick = feedback_source_select_in ? ref_tick : 1'b1;
  assign fbk_if.tick_in = src_tick;
  assign fbk_if.modulus = feedback_modulus_in;
  pdpa_div_stage #(.W(FBK_W)) u_fbk (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .div(fbk_if)
  );

  // ---------------- phase sampling ----------------
  logic out_rose;         // output rose on the previous oscillator cycle
  logic next_out_rose;
  logic aligned;          // last comparison found the clocks matched
  logic next_aligned;
  logic flag;             // phase alignment flag
  logic next_flag;
  logic hit;

  // sampling happens at every feedback divider rising edge; a hit needs an
  // output edge no older than one period of the clock at the post
  // divider input, so each slip walks the output across the window
  always_comb begin
    hit = post_tick | out_rose;
    // a window as wide as the post period would match on every sample
    next_out_rose = post_tick;
    next_aligned = aligned;
    next_flag = flag;
    if (fbk_if.tick_out) begin
      next_aligned = hit;
      if (hit && !aligned) begin
        next_flag = ~flag;
      end
    end
  end

  // register the comparison state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_rose <= 1'b0;
      aligned <= 1'b0;
      flag <= pdpa_pkg::RST_FLAG;
    end else begin
      out_rose <= next_out_rose;
      aligned <= next_aligned;
      flag <= next_flag;
    end
  end

  // ---------------- pin function and outputs ----------------
  pdpa_pkg::pdpa_pin_func_t pf;
  logic monitor;               // signal chosen by the pin function
  logic next_readback;
  logic next_pin;
  logic next_oe;
  logic [3*POST_W-1:0] next_total;

  assign pf = pdpa_pkg::pdpa_pin_func_t'(pin_function_in);

  // choose what the lock indicator pin and the readback show
  always_comb begin
    next_readback = pin_function_in[1];
    monitor = 1'b0;
    unique case (pf)
      pdpa_pkg::PDPA_PF_LOCK: begin
        monitor = stable[pdpa_pkg::SYNC_LOCK];
        next_readback = monitor;
      end
      pdpa_pkg::PDPA_PF_RANGE: begin
        monitor = stable[pdpa_pkg::SYNC_RANGE];
        next_readback = monitor;
      end
      pdpa_pkg::PDPA_PF_PHASE: begin
        monitor = flag;
        next_readback = flag;
      end
      pdpa_pkg::PDPA_PF_FBKCLK: begin
        monitor = fbk_if.level;
        next_readback = pin_function_in[1];
      end
    endcase
    // without push-pull the pin is released and shows nothing
    next_oe = push_pull_select_in;
    next_pin = push_pull_select_in & monitor;
    next_total = eff_mod(post_modulus1_in) * eff_mod(post_modulus2_in)
                 * eff_mod(post_modulus3_in);
  end

  // every output leaves from a flip-flop
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      diff_clock_out_pos_out <= 1'b0;
      diff_clock_out_neg_out <= 1'b1;
      total_post_modulus_out <= '0;
      feedback_clock_out <= 1'b0;
      phase_align_flag_out <= pdpa_pkg::RST_FLAG;
      status_readback_out <= 1'b0;
      lock_indicator_pin_out <= pdpa_pkg::RST_PIN;
      lock_indicator_pin_oe_out <= 1'b0;
    end else begin
      diff_clock_out_pos_out <= post_level;
      diff_clock_out_neg_out <= ~post_level;
      total_post_modulus_out <= next_total;
      feedback_clock_out <= fbk_if.level;
      phase_align_flag_out <= flag;
      status_readback_out <= next_readback;
      lock_indicator_pin_out <= next_pin;
      lock_indicator_pin_oe_out <= next_oe;
    end
  end
endmodule
`default_nettype wire

/* verif/pdpa_top_assertions.sv */
// Purpose: port checks for the post divider and phase align block
// Assumes: one clock, synchronous active-high reset
// Notes: registered outputs follow the inputs of the previous edge
`timescale 1ns/100ps
`default_nettype none
module pdpa_top_assertions #(
  parameter int unsigned POST_W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic push_pull_select_in,
  input wire logic [1:0] pin_function_in,
  input wire logic [POST_W-1:0] post_modulus1_in,
  input wire logic [POST_W-1:0] post_modulus2_in,
  input wire logic [POST_W-1:0] post_modulus3_in,
  input wire logic diff_clock_out_pos_out,
  input wire logic diff_clock_out_neg_out,
  input wire logic [3*POST_W-1:0] total_post_modulus_out,
  input wire logic status_readback_out,
  input wire logic lock_indicator_pin_out,
  input wire logic lock_indicator_pin_oe_out
);
  // zero modulus counts as one, as the stages treat it
  function automatic logic [3*POST_W-1:0] eff(input logic [POST_W-1:0] m);
    eff = {{(2*POST_W){1'b0}}, m};
    if (m == '0) begin
      eff[0] = 1'b1;
    end
  endfunction
  logic [3*POST_W-1:0] prod; // expected total modulus
  assign prod = eff(post_modulus1_in) * eff(post_modulus2_in) * eff(post_modulus3_in);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // the past guard keeps the first edge after reset from seeing reset values
  neg_inverse_a: assert property (diff_clock_out_neg_out == !diff_clock_out_pos_out)
    else $error("negative clock is not the inverse of positive");
  total_product_a: assert property (!$past(rst_in) |-> total_post_modulus_out == $past(prod))
    else $error("total modulus is not the stage product");
  oe_follows_a: assert property (!$past(rst_in) |->
    lock_indicator_pin_oe_out == $past(push_pull_select_in))
    else $error("pin enable does not follow push-pull select");
  pin_released_a: assert property (!lock_indicator_pin_oe_out |-> !lock_indicator_pin_out)
    else $error("pin value shown while not driven");
  fbk_readback_a: assert property (!$past(rst_in) && $past(pin_function_in) == 2'h3
    |-> status_readback_out)
    else $error("readback not the written bit in clock mode");
  phase_pin_a: assert property (!$past(rst_in) && $past(pin_function_in) == 2'h2
    && $past(push_pull_select_in) |-> lock_indicator_pin_out == status_readback_out)
    else $error("pin and readback differ in phase mode");
  lock_pin_a: assert property (!$past(rst_in) && $past(pin_function_in) == 2'h0
    && $past(push_pull_select_in) |-> lock_indicator_pin_out == status_readback_out)
    else $error("pin and readback differ in lock mode");
  range_pin_a: assert property (!$past(rst_in) && $past(pin_function_in) == 2'h1
    && $past(push_pull_select_in) |-> lock_indicator_pin_out == status_readback_out)
    else $error("pin and readback differ in range mode");
endmodule
bind pdpa_top pdpa_top_assertions #(.POST_W(POST_W)) u_chk (.mclk_in, .rst_in,
  .push_pull_select_in, .pin_function_in, .post_modulus1_in, .post_modulus2_in,
  .post_modulus3_in, .diff_clock_out_pos_out, .diff_clock_out_neg_out,
  .total_post_modulus_out, .status_readback_out, .lock_indicator_pin_out,
  .lock_indicator_pin_oe_out);
`default_nettype wire

/* verif/pdpa_top_bench.sv */
// Purpose: self-checking bench for the post divider and phase align block
// Assumes: inputs change by non-blocking assignment at the rising edge; the phase mode pin_function_in write lands at a falling edge
// Notes: outputs are sampled at the falling edge, once settled
`timescale 1ns/100ps
`default_nettype none
module pdpa_top_bench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic slip_request_bit_in = 1'b0;
  logic feedback_source_select_in = 1'b0;
  logic [1:0] pin_function_in = 2'h0;
  logic push_pull_select_in = 1'b0;
  logic [7:0] post_modulus1_in = 8'h1;
  logic [7:0] post_modulus2_in = 8'h1;
  logic [7:0] post_modulus3_in = 8'h2;
  logic [13:0] feedback_modulus_in = 14'h2;
  logic xtal_lock_in = 1'b0;
  logic out_of_range_high_in = 1'b0;
  logic diff_clock_out_pos_out, diff_clock_out_neg_out, feedback_clock_out;
  logic phase_align_flag_out, status_readback_out;
  logic lock_indicator_pin_out, lock_indicator_pin_oe_out;
  logic [23:0] total_post_modulus_out;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0; // free cycle count, used to time rises
  int hi, per, t0, t1;
  logic f0;
  pdpa_top dut (.mclk_in, .rst_in, .slip_request_bit_in, .feedback_source_select_in,
    .pin_function_in, .push_pull_select_in, .post_modulus1_in, .post_modulus2_in,
    .post_modulus3_in, .feedback_modulus_in, .xtal_lock_in, .out_of_range_high_in,
    .diff_clock_out_pos_out, .diff_clock_out_neg_out, .total_post_modulus_out,
    .feedback_clock_out, .phase_align_flag_out, .status_readback_out,
    .lock_indicator_pin_out, .lock_indicator_pin_oe_out);
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) cyc <= cyc + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic sig(input bit f);
    return f ? feedback_clock_out : diff_clock_out_pos_out;
  endfunction
  // one full period from a rise: high cycles, period, rise time; bounded waits
  task automatic measure(input bit f, output int h, output int p, output int t);
    int n;
    n = 0;
    h = 0;
    do begin @(negedge mclk_in); n++; end while (sig(f) !== 1'b0 && n < 4000);
    do begin @(negedge mclk_in); n++; end while (sig(f) !== 1'b1 && n < 4000);
    t = cyc;
    do begin @(negedge mclk_in); h++; end while (sig(f) === 1'b1 && h < 4000);
    p = h;
    do begin @(negedge mclk_in); p++; end while (sig(f) === 1'b0 && p < 8000);
  endtask
  // new moduli and source, then let every stage pass its old count
  task automatic setup(input int a, input int b, input int c, input int f, input bit s);
    @(posedge mclk_in);
    post_modulus1_in <= 8'(a);
    post_modulus2_in <= 8'(b);
    post_modulus3_in <= 8'(c);
    feedback_modulus_in <= 14'(f);
    feedback_source_select_in <= s;
    repeat (300) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  // slip levels are held six cycles, past the synchroniser
  task automatic slip();
    @(posedge mclk_in);
    slip_request_bit_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    slip_request_bit_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask
  initial begin
    #(4 * 60000);
    err_count++;
    end_sim();
  end
  initial begin
    int a, b, c, m, e;
    void'($urandom(32'h40cb7390));
    repeat (7) @(posedge mclk_in);
    @(negedge mclk_in);
    check("reset outputs", {diff_clock_out_pos_out, diff_clock_out_neg_out,
      total_post_modulus_out, feedback_clock_out, phase_align_flag_out, status_readback_out,
      lock_indicator_pin_out, lock_indicator_pin_oe_out}, {1'b0, 1'b1, 29'h0});
    @(posedge mclk_in);
    rst_in <= 1'b0;
    // products over random moduli, zero and full scale among them
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 256;
      b = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 256;
      c = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 256;
      setup(a, b, c, 2, 0);
      check("total modulus", total_post_modulus_out,
        (a ? a : 1) * (b ? b : 1) * (c ? c : 1));
    end
    // cascade period and balance, odd and even last stage
    for (int i = 0; i < 5; i++) begin
      a = (i == 2) ? 2 : (i > 2) ? 1 + $urandom % 4 : 1;
      b = (i == 2) ? 3 : (i > 2) ? 1 + $urandom % 4 : 1;
      c = (i == 0) ? 3 : (i == 1) ? 4 : (i == 2) ? 5 : 2 + $urandom % 6;
      setup(a, b, c, 2, 0);
      measure(0, hi, per, t0);
      check("post period", per, a * b * c);
      check("post high time", hi, ((c + 1) / 2) * a * b);
    end
    // three slips, falling edges between them, shift the output by three
    setup(2, 1, 3, 6, 1);
    measure(0, hi, per, t0);
    repeat (3) slip();
    measure(0, hi, per, t1);
    check("slip shift", (t1 - t0) % 6, 3);
    setup(1, 1, 1, 5, 0);
    measure(1, hi, per, t0);
    check("feedback period osc", per, 5);
    setup(1, 1, 2, 3, 1);
    measure(1, hi, per, t0);
    check("feedback period post", per, 6);
    // post path in the loop, feedback a multiple, single slips until flag moves
    pin_function_in <= 2'h2;
    setup(1, 1, 4, 8, 1);
    f0 = phase_align_flag_out;
    for (int i = 0; i < 12 && phase_align_flag_out === f0; i++) begin
      slip();
      repeat (40) @(posedge mclk_in);
      @(negedge mclk_in);
    end
    check("flag moved", phase_align_flag_out !== f0, 1);
    setup(1, 1, 4, 4, 0);
    // every pin function with drive on and off
    for (int i = 0; i < 8; i++) begin
      m = i % 4;
      @(posedge mclk_in);
      pin_function_in <= 2'(m);
      push_pull_select_in <= i > 3;
      xtal_lock_in <= $urandom % 2;
      out_of_range_high_in <= $urandom % 2;
      repeat (10) @(posedge mclk_in);
      @(negedge mclk_in);
      f0 = phase_align_flag_out;
      e = (m == 0) ? xtal_lock_in : (m == 1) ? out_of_range_high_in : (m == 2) ? f0 : 1;
      check("pin enable", lock_indicator_pin_oe_out, i > 3);
      if (m != 2 || phase_align_flag_out === f0) begin
        check("readback", status_readback_out, e);
      end
      check("pin value", lock_indicator_pin_out,
        (i > 3) ? ((m == 3) ? feedback_clock_out : e) : 0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
